/* adcrg_defines.vh */
// Register map, field positions and reset values of the record channel bank.
`ifndef ADCRG_DEFINES_VH
`define ADCRG_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADCRG_ADC1_FINE_GAIN_CFG_ADDR  8'h53
`define ADCRG_ADC1_PHASE_CAL_CFG_ADDR  8'h54
`define ADCRG_ADC2_INPUT_CFG_ADDR      8'h55
`define ADCRG_ADC2_VOLUME_CFG_ADDR     8'h57

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ADCRG_FINE_GAIN_RST            4'h8
`define ADCRG_PHASE_DELAY_RST          6'h00
`define ADCRG_PCAL_SEL_RST             2'h0
`define ADCRG_INPUT_SOURCE_RST         2'h0
`define ADCRG_CM_TOL_RST               2'h0
`define ADCRG_FULL_SCALE_RST           1'h0
`define ADCRG_BANDWIDTH_RST            1'h0
`define ADCRG_VOLUME_RST               8'ha1
`define ADCRG_UNMAPPED_RDATA           8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADCRG_FINE_GAIN_MSB            7
`define ADCRG_FINE_GAIN_LSB            4
`define ADCRG_PHASE_DELAY_MSB          7
`define ADCRG_PHASE_DELAY_LSB          2
`define ADCRG_PCAL_SEL_MSB             1
`define ADCRG_PCAL_SEL_LSB             0
`define ADCRG_INPUT_SOURCE_MSB         7
`define ADCRG_INPUT_SOURCE_LSB         6
`define ADCRG_CM_TOL_MSB               3
`define ADCRG_CM_TOL_LSB               2
`define ADCRG_FULL_SCALE_BIT           1
`define ADCRG_BANDWIDTH_BIT            0

// ----------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------
`define ADCRG_FINE_GAIN_ZERO_DB        5'sh08
`define ADCRG_PCAL_BOTH                2'h0
`define ADCRG_PCAL_ANA_ONLY            2'h1
`define ADCRG_PCAL_DIG_ONLY            2'h2
`define ADCRG_SRC_DIFFERENTIAL         2'h0
`define ADCRG_SRC_SINGLE_ENDED         2'h1
`define ADCRG_CM_TOL_RAIL              2'h2
`define ADCRG_PHASE_DELAY_MAX          63

`endif

/* adcrg_phase_delay.v */
// Variable delay line for the channel-1 modulator stream.
`timescale 1ns/10ps
`default_nettype none

module adcrg_phase_delay #(
    parameter WIDTH = 1,
    parameter DEPTH = 63
) (
    // Clock and reset.
    input  wire             sys_clk_i,
    input  wire             rst_i,
    // Delay setting.
    input  wire [5:0]       delay_i,
    input  wire             enable_i,
    // Modulator stream.
    input  wire             mod_tick_i,
    input  wire [WIDTH-1:0] data_i,
    output reg  [WIDTH-1:0] data_o
);

    reg  [WIDTH-1:0] stage_r [0:DEPTH-1];
    reg  [WIDTH-1:0] tap;
    integer          i;

    // ------------------------------------------------------------------
    // Delay stages
    // ------------------------------------------------------------------

    // Each modulator tick moves every sample one stage further on.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                stage_r[i] <= {WIDTH{1'b0}};
            end
        end else if (mod_tick_i) begin
            stage_r[0] <= data_i;
            for (i = 1; i < DEPTH; i = i + 1) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    // Stage n-1 holds the sample n modulator cycles old; zero taps the input.
    always @* begin
        if (!enable_i || delay_i == 6'h00) begin
            tap = data_i;
        end else begin
            tap = stage_r[delay_i - 6'h01];
        end
    end

    // The output flop adds one fixed system cycle whatever the delay.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= {WIDTH{1'b0}};
        end else begin
            data_o <= tap;
        end
    end

endmodule // adcrg_phase_delay

`default_nettype wire

/* adcrg_regs.v */
// Configuration registers of the record channels, with the phase delay.
//
// Function
// - Channel-1 fine gain is read/write bits 7:4, reset code 8.
// - Fine gain code maps linearly, 0.1 dB steps, code 8 is 0 dB.
// - Fine gain low nibble is reserved, reads zero; software writes zero.
// - Channel-1 path is delayed by bits 7:2 modulator cycles, 0 to 63.
// - Bits 1:0 apply phase calibration to both, analog only or digital only.
// - Channel-2 source code 0 is differential, code 1 single-ended.
// - Bits 3:2 pick common-mode tolerance: AC, wider, rail-to-rail.
// - Bit 1 picks full scale: 0 is 10 Vrms, 1 is 5 Vrms.
// - Bit 0 picks bandwidth: 0 is 24 kHz, 1 is 96 kHz.
// - Channel-2 input bits 5:4 are reserved, read zero; software writes zero.
`timescale 1ns/10ps
`default_nettype none
`include "adcrg_defines.vh"

module adcrg_regs #(
    parameter MOD_WIDTH = 1
) (
    // Clock and reset.
    input  wire                 sys_clk_i,
    input  wire                 rst_i,
    // Register access port.
    input  wire [7:0]           reg_addr_i,
    input  wire                 reg_wr_i,
    input  wire [7:0]           reg_wdata_i,
    input  wire                 reg_rd_i,
    output reg  [7:0]           reg_rdata_o,
    // Channel-1 gain settings.
    output wire [3:0]           ch1_fine_gain_trim_o,
    output reg  signed [4:0]    ch1_fine_gain_tenth_db_o,
    // Channel-1 phase calibration.
    output wire [5:0]           ch1_phase_delay_o,
    output reg                  ch1_pcal_ana_en_o,
    output reg                  ch1_pcal_dig_en_o,
    input  wire                 mod_tick_i,
    input  wire [MOD_WIDTH-1:0] ch1_mod_data_i,
    output wire [MOD_WIDTH-1:0] ch1_mod_data_o,
    // Channel-2 input settings.
    output wire [1:0]           ch2_input_source_o,
    output reg                  ch2_single_ended_o,
    output wire [1:0]           ch2_common_mode_tolerance_o,
    output reg                  ch2_rail_to_rail_o,
    output wire                 ch2_full_scale_select_o,
    output wire                 ch2_bandwidth_select_o,
    output wire [7:0]           ch2_digital_volume_o
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg  [3:0] fine_gain_r;
    reg  [5:0] phase_delay_r;
    reg  [1:0] pcal_sel_r;
    reg  [1:0] input_source_r;
    reg  [1:0] cm_tol_r;
    reg        full_scale_r;
    reg        bandwidth_r;
    reg  [7:0] volume_r;
    reg  [7:0] rdata_nxt;

    // Write decode for one register address.
    function wr_hit;
        input [7:0] addr;
        input       wr;
        input [7:0] target;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    // Only the read/write fields take data; reserved bits have no flop.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fine_gain_r    <= `ADCRG_FINE_GAIN_RST;
            phase_delay_r  <= `ADCRG_PHASE_DELAY_RST;
            pcal_sel_r     <= `ADCRG_PCAL_SEL_RST;
            input_source_r <= `ADCRG_INPUT_SOURCE_RST;
            cm_tol_r       <= `ADCRG_CM_TOL_RST;
            full_scale_r   <= `ADCRG_FULL_SCALE_RST;
            bandwidth_r    <= `ADCRG_BANDWIDTH_RST;
            volume_r       <= `ADCRG_VOLUME_RST;
        end else begin
            if (wr_hit(reg_addr_i, reg_wr_i,
                       `ADCRG_ADC1_FINE_GAIN_CFG_ADDR)) begin
                fine_gain_r <= reg_wdata_i[`ADCRG_FINE_GAIN_MSB:
                                           `ADCRG_FINE_GAIN_LSB];
            end
            if (wr_hit(reg_addr_i, reg_wr_i,
                       `ADCRG_ADC1_PHASE_CAL_CFG_ADDR)) begin
                phase_delay_r <= reg_wdata_i[`ADCRG_PHASE_DELAY_MSB:
                                             `ADCRG_PHASE_DELAY_LSB];
                pcal_sel_r    <= reg_wdata_i[`ADCRG_PCAL_SEL_MSB:
                                             `ADCRG_PCAL_SEL_LSB];
            end
            if (wr_hit(reg_addr_i, reg_wr_i,
                       `ADCRG_ADC2_INPUT_CFG_ADDR)) begin
                input_source_r <= reg_wdata_i[`ADCRG_INPUT_SOURCE_MSB:
                                              `ADCRG_INPUT_SOURCE_LSB];
                cm_tol_r       <= reg_wdata_i[`ADCRG_CM_TOL_MSB:
                                              `ADCRG_CM_TOL_LSB];
                full_scale_r   <= reg_wdata_i[`ADCRG_FULL_SCALE_BIT];
                bandwidth_r    <= reg_wdata_i[`ADCRG_BANDWIDTH_BIT];
            end
            if (wr_hit(reg_addr_i, reg_wr_i,
                       `ADCRG_ADC2_VOLUME_CFG_ADDR)) begin
                volume_r <= reg_wdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Reserved positions and unmapped addresses read as zero.
    always @* begin
        case (reg_addr_i)
            `ADCRG_ADC1_FINE_GAIN_CFG_ADDR: begin
                rdata_nxt = {fine_gain_r, 4'h0};
            end
            `ADCRG_ADC1_PHASE_CAL_CFG_ADDR: begin
                rdata_nxt = {phase_delay_r, pcal_sel_r};
            end
            `ADCRG_ADC2_INPUT_CFG_ADDR: begin
                rdata_nxt = {input_source_r, 2'h0, cm_tol_r,
                             full_scale_r, bandwidth_r};
            end
            `ADCRG_ADC2_VOLUME_CFG_ADDR: begin
                rdata_nxt = volume_r;
            end
            default: begin
                rdata_nxt = `ADCRG_UNMAPPED_RDATA;
            end
        endcase
    end

    // Read data is captured on a read strobe and held until the next one.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Decoded settings
    // ------------------------------------------------------------------

    // Fine gain in tenths of a dB: code minus eight, -8 up to +7.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ch1_fine_gain_tenth_db_o <= 5'sh00;
        end else begin
            ch1_fine_gain_tenth_db_o <= $signed({1'b0, fine_gain_r})
                                        - `ADCRG_FINE_GAIN_ZERO_DB;
        end
    end

    // Scope of phase calibration; the reserved code applies it nowhere.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ch1_pcal_ana_en_o <= 1'b1;
            ch1_pcal_dig_en_o <= 1'b1;
        end else begin
            case (pcal_sel_r)
                `ADCRG_PCAL_BOTH: begin
                    ch1_pcal_ana_en_o <= 1'b1;
                    ch1_pcal_dig_en_o <= 1'b1;
                end
                `ADCRG_PCAL_ANA_ONLY: begin
                    ch1_pcal_ana_en_o <= 1'b1;
                    ch1_pcal_dig_en_o <= 1'b0;
                end
                `ADCRG_PCAL_DIG_ONLY: begin
                    ch1_pcal_ana_en_o <= 1'b0;
                    ch1_pcal_dig_en_o <= 1'b1;
                end
                default: begin
                    ch1_pcal_ana_en_o <= 1'b0;
                    ch1_pcal_dig_en_o <= 1'b0;
                end
            endcase
        end
    end

    // Source and tolerance flags; forbidden source codes are left to software.
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ch2_single_ended_o <= 1'b0;
            ch2_rail_to_rail_o <= 1'b0;
        end else begin
            ch2_single_ended_o <= (input_source_r ==
                                   `ADCRG_SRC_SINGLE_ENDED);
            ch2_rail_to_rail_o <= (cm_tol_r == `ADCRG_CM_TOL_RAIL);
        end
    end

    // Raw fields go to the analog path straight from their flops.
    assign ch1_fine_gain_trim_o        = fine_gain_r;
    assign ch1_phase_delay_o           = phase_delay_r;
    assign ch2_input_source_o          = input_source_r;
    assign ch2_common_mode_tolerance_o = cm_tol_r;
    assign ch2_full_scale_select_o     = full_scale_r;
    assign ch2_bandwidth_select_o      = bandwidth_r;
    assign ch2_digital_volume_o        = volume_r;

    // ------------------------------------------------------------------
    // Digital phase delay
    // ------------------------------------------------------------------

    // The digital stream is delayed only when digital scope is enabled.
    adcrg_phase_delay #(
        .WIDTH (MOD_WIDTH),
        .DEPTH (`ADCRG_PHASE_DELAY_MAX)
    ) u_phase_delay (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .delay_i    (phase_delay_r),
        .enable_i   (ch1_pcal_dig_en_o),
        .mod_tick_i (mod_tick_i),
        .data_i     (ch1_mod_data_i),
        .data_o     (ch1_mod_data_o)
    );

endmodule // adcrg_regs

`default_nettype wire

/* adcrg_regs_checker.sv */
// Concurrent checks on the ports of the record channel register bank.
`timescale 1ns/10ps
`default_nettype none
module adcrg_regs_checker (
    // Clock, reset and register port.
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic [7:0]        reg_addr_i,
    input wire logic              reg_wr_i,
    input wire logic [7:0]        reg_wdata_i,
    input wire logic              reg_rd_i,
    input wire logic [7:0]        reg_rdata_o,
    // Configuration outputs.
    input wire logic [3:0]        ch1_fine_gain_trim_o,
    input wire logic signed [4:0] ch1_fine_gain_tenth_db_o,
    input wire logic [5:0]        ch1_phase_delay_o,
    input wire logic              ch1_pcal_ana_en_o,
    input wire logic              ch1_pcal_dig_en_o,
    input wire logic [1:0]        ch2_input_source_o,
    input wire logic              ch2_single_ended_o,
    input wire logic [1:0]        ch2_common_mode_tolerance_o,
    input wire logic              ch2_rail_to_rail_o,
    input wire logic              ch2_full_scale_select_o,
    input wire logic              ch2_bandwidth_select_o,
    input wire logic [7:0]        ch2_digital_volume_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Decoded register strobes.
    logic w53, w54, w55, r53, r55;
    assign w53 = reg_wr_i && (reg_addr_i == 8'h53);
    assign w54 = reg_wr_i && (reg_addr_i == 8'h54);
    assign w55 = reg_wr_i && (reg_addr_i == 8'h55);
    assign r53 = reg_rd_i && (reg_addr_i == 8'h53);
    assign r55 = reg_rd_i && (reg_addr_i == 8'h55);

    a_gain_write: assert property (
        w53 |=> ch1_fine_gain_trim_o == $past(reg_wdata_i[7:4]))
        else $error("fine gain field did not take the write");
    a_gain_scale: assert property (
        ch1_fine_gain_tenth_db_o
        == $past({1'b0, ch1_fine_gain_trim_o}) - 5'h08)
        else $error("fine gain step value wrong");
    a_gain_rsvd: assert property (
        r53 |=> reg_rdata_o == {$past(ch1_fine_gain_trim_o), 4'h0})
        else $error("fine gain read back wrong");
    a_delay_write: assert property (
        w54 |=> ch1_phase_delay_o == $past(reg_wdata_i[7:2]))
        else $error("phase delay field did not take the write");
    a_pcal_scope: assert property (
        w54 ##1 !w54 |=> ch1_pcal_ana_en_o == !$past(reg_wdata_i[1], 2)
        && ch1_pcal_dig_en_o == !$past(reg_wdata_i[0], 2))
        else $error("phase calibration scope wrong");
    a_src_decode: assert property (
        ch2_single_ended_o == ($past(ch2_input_source_o) == 2'h1))
        else $error("single ended flag wrong");
    a_rail_decode: assert property (
        ch2_rail_to_rail_o == ($past(ch2_common_mode_tolerance_o) == 2'h2))
        else $error("rail to rail flag wrong");
    a_ch2_write: assert property (
        w55 |=> {ch2_input_source_o, ch2_common_mode_tolerance_o,
        ch2_full_scale_select_o, ch2_bandwidth_select_o}
        == {$past(reg_wdata_i[7:6]), $past(reg_wdata_i[3:0])})
        else $error("channel 2 fields did not take the write");
    a_ch2_rsvd: assert property (
        r55 |=> reg_rdata_o == {$past(ch2_input_source_o), 2'h0,
        $past(ch2_common_mode_tolerance_o), $past(ch2_full_scale_select_o),
        $past(ch2_bandwidth_select_o)})
        else $error("channel 2 read back wrong");
    a_hold_value: assert property (
        !reg_wr_i |=> $stable(ch1_fine_gain_trim_o)
        && $stable(ch1_phase_delay_o) && $stable(ch2_digital_volume_o))
        else $error("field changed without a write");

    // Main scenarios.
    c_gain: cover property (w53);
    c_pcal: cover property (w54 ##1 !w54);
    c_ch2: cover property (w55);
endmodule // adcrg_regs_checker

bind adcrg_regs adcrg_regs_checker u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ch1_fine_gain_trim_o(ch1_fine_gain_trim_o),
    .ch1_fine_gain_tenth_db_o(ch1_fine_gain_tenth_db_o),
    .ch1_phase_delay_o(ch1_phase_delay_o),
    .ch1_pcal_ana_en_o(ch1_pcal_ana_en_o),
    .ch1_pcal_dig_en_o(ch1_pcal_dig_en_o),
    .ch2_input_source_o(ch2_input_source_o),
    .ch2_single_ended_o(ch2_single_ended_o),
    .ch2_common_mode_tolerance_o(ch2_common_mode_tolerance_o),
    .ch2_rail_to_rail_o(ch2_rail_to_rail_o),
    .ch2_full_scale_select_o(ch2_full_scale_select_o),
    .ch2_bandwidth_select_o(ch2_bandwidth_select_o),
    .ch2_digital_volume_o(ch2_digital_volume_o));
`default_nettype wire

/* adcrg_regs_tb.sv */
// Self-checking testbench of the record channel register bank.
`timescale 1ns/10ps
`default_nettype none
module adcrg_regs_tb;
    logic              sys_clk_i, rst_i, reg_wr_i, reg_rd_i, mod_tick_i;
    logic [7:0]        reg_addr_i, reg_wdata_i, reg_rdata_o, vol;
    logic [0:0]        ch1_mod_data_i, ch1_mod_data_o;
    logic [3:0]        trim;
    logic signed [4:0] tdb;
    logic [5:0]        dly;
    logic [1:0]        src, cmt;
    logic              ana, dig, se, rail, fs, bw;
    int                num_errors = 0;
    int                num_checks = 0;

    adcrg_regs uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .ch1_fine_gain_trim_o(trim),
        .ch1_fine_gain_tenth_db_o(tdb), .ch1_phase_delay_o(dly),
        .ch1_pcal_ana_en_o(ana), .ch1_pcal_dig_en_o(dig),
        .mod_tick_i(mod_tick_i), .ch1_mod_data_i(ch1_mod_data_i),
        .ch1_mod_data_o(ch1_mod_data_o), .ch2_input_source_o(src),
        .ch2_single_ended_o(se), .ch2_common_mode_tolerance_o(cmt),
        .ch2_rail_to_rail_o(rail), .ch2_full_scale_select_o(fs),
        .ch2_bandwidth_select_o(bw), .ch2_digital_volume_o(vol));

    // A 125 MHz clock.
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic finish_test;
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs move 1 ns after the rising edge.
    task automatic cyc;
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        cyc();
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        cyc();
        reg_wr_i = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        cyc();
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        cyc();
        reg_rd_i = 1'b0;
        check(reg_rdata_o, exp);
    endtask

    // Reset image of every register, the unmapped hole and the decodes.
    task automatic t_reset;
        rd_chk(8'h53, 8'h80);
        rd_chk(8'h54, 8'h00);
        rd_chk(8'h55, 8'h00);
        rd_chk(8'h57, 8'ha1);
        rd_chk(8'h56, 8'h00);
        check({2'h0, ana, dig, se, rail, tdb[1:0]}, 8'h30);
        check({3'h0, tdb}, 8'h00);
    endtask

    // Every fine gain code, reserved bits written as ones.
    task automatic t_gain;
        for (int i = 0; i < 16; i++) begin
            wr_reg(8'h53, {i[3:0], 4'hf});
            rd_chk(8'h53, {i[3:0], 4'h0});
            check({3'h0, tdb}, {3'h0, i[4:0] - 5'h08});
            check({4'h0, trim}, {4'h0, i[3:0]});
        end
    endtask

    // Every scope code with the largest delay.
    task automatic t_pcal;
        for (int s = 0; s < 4; s++) begin
            wr_reg(8'h54, {6'h3f, s[1:0]});
            cyc();
            check({ana, dig}, {!s[1], !s[0]});
            check({2'h0, dly}, 8'h3f);
            rd_chk(8'h54, {6'h3f, s[1:0]});
        end
    endtask

    // Edges from a single one on the stream to its arrival at the output.
    // With slow set the modulator ticks only on every other edge.
    task automatic t_delay(input logic [7:0] w, input logic [7:0] exp,
                           input logic slow);
        int n;
        wr_reg(8'h54, w);
        repeat (70) cyc();
        mod_tick_i = 1'b1;
        ch1_mod_data_i = 1'b1;
        n = 0;
        while (ch1_mod_data_o !== 1'b1 && n < 100) begin
            cyc();
            ch1_mod_data_i = 1'b0;
            mod_tick_i = slow ? ~mod_tick_i : 1'b1;
            n = n + 1;
        end
        mod_tick_i = 1'b1;
        check(n[7:0], exp);
    endtask

    // Channel-2 settings; source codes 2 and 3 are never written.
    task automatic t_ch2;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            d = {1'b0, i[2], 2'h3, i[1:0], i[0], i[1]};
            wr_reg(8'h55, d);
            rd_chk(8'h55, d & 8'hcf);
            check({src, cmt, fs, bw}, {d[7:6], d[3:0]});
            check({se, rail}, {i[2], i[1:0] == 2'h2});
        end
    endtask

    // Volume write, unmapped write, then a reset in mid-run.
    task automatic t_misc;
        wr_reg(8'h57, 8'h5c);
        check(vol, 8'h5c);
        wr_reg(8'h56, 8'hff);
        rd_chk(8'h56, 8'h00);
        rd_chk(8'h57, 8'h5c);
        rst_i = 1'b1;
        repeat (2) cyc();
        rst_i = 1'b0;
        t_reset();
    endtask

    // Cuts a hung run short.
    initial begin
        #100000;
        num_errors = num_errors + 1;
        finish_test();
    end

    // Main sequence.
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, mod_tick_i} = 4'h9;
        {reg_addr_i, reg_wdata_i, ch1_mod_data_i} = 17'h0;
        repeat (12) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        t_gain();
        t_pcal();
        t_delay(8'h00, 8'h01, 1'b0);
        t_delay(8'h14, 8'h06, 1'b0);
        t_delay(8'hfc, 8'h40, 1'b0);
        t_delay(8'h14, 8'h0a, 1'b1);
        t_delay(8'h15, 8'h01, 1'b0);
        t_delay(8'h16, 8'h06, 1'b0);
        t_ch2();
        t_misc();
        finish_test();
    end
endmodule // adcrg_regs_tb
`default_nettype wire
